// ---- src/dvs_pkg.sv ----
package dvs_pkg;

	// Register pointer values carried in the two low bits of the register address byte
	localparam logic [1:0] REG_FLOOR = 2'h0;
	localparam logic [1:0] REG_ROOF  = 2'h1;
	localparam logic [1:0] REG_MODE  = 2'h2;
	localparam logic [1:0] REG_RAMP  = 2'h3;

	// Address decode
	localparam logic [4:0] ADDR_FIXED      = 5'h12;
	localparam logic [1:0] ADDR_OPTION_DEF = 2'h0;
	localparam logic [4:0] HS_CODE_TOP     = 5'h01;
	localparam logic [7:0] READ_MISS       = 8'hFF;
	localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

	// Voltage register fields
	localparam int         BIT_ENABLE = 7;
	localparam int         BIT_LPFM   = 6;
	localparam int         CODE_MSB   = 5;
	localparam logic [1:0] VOLT_TOP_RESET = 2'h3;
	localparam logic [5:0] FLOOR_CODE_DEF = 6'h00;
	localparam logic [5:0] ROOF_CODE_DEF  = 6'h00;

	// Mode and ramp control fields
	localparam int         BIT_FLOOR_MODE = 0;
	localparam int         BIT_ROOF_MODE  = 1;
	localparam int         BIT_STRATEGY   = 4;
	localparam int         BIT_GO         = 5;
	localparam int         RATE_MSB       = 2;
	localparam logic [2:0] RATE_SINGLE    = 3'h7;
	localparam logic [7:0] MODE_RESET     = 8'h00;
	localparam logic [7:0] RAMP_RESET     = 8'h07;

	// Micro-step spacing at the fastest rate; each higher rate code doubles it
	localparam int CLK_PERIOD_NS = 10;
	localparam int STEP_NS       = 1000;
	localparam int STEP_CYCLES   = (STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum {ST_IDLE, ST_ADDR, ST_REG, ST_DATA, ST_READ, ST_SKIP} bus_state_t;

	typedef struct packed {
		logic scl;
		logic sda;
		logic en;
		logic sel;
		logic below;
		logic pulse;
	} pins_t;

	typedef struct packed {
		logic [7:0] data;
		logic       tog;
	} link_byte_t;

	typedef struct packed {
		logic [7:0] shift;
		logic [3:0] cnt;
		link_byte_t rx;
	} link_state_t;

	typedef struct packed {
		pins_t       s1;
		pins_t       s2;
		pins_t       pv;
		logic        t1;
		logic        t2;
		logic        t3;
		logic [7:0]  byte_q;
		bus_state_t  st;
		logic        pend;
		logic        ack_ph;
		logic        rd_wait;
		logic        ptr_bad;
		logic        hs;
		logic        lclr;
		logic        sda_oe;
		logic        sda_lvl;
		logic [3:0]  rd_cnt;
		logic [7:0]  sh;
		logic [1:0]  ptr;
		logic [7:0]  floor_v;
		logic [7:0]  roof_v;
		logic [7:0]  mode_c;
		logic [7:0]  ramp_c;
		logic [5:0]  vout;
		logic [15:0] step_cnt;
		logic        pfm_hold;
		logic        pgood;
		logic        conv_on;
		logic        fpwm;
	} core_state_t;

endpackage

// ---- src/link_byte_receiver.sv ----
`timescale 1ns/10ps
module link_byte_receiver (
	input  wire logic          scl_clk,
	input  wire logic          clear_n,
	input  wire logic          sda_in,
	output dvs_pkg::link_byte_t rx
);
	dvs_pkg::link_state_t s;
	dvs_pkg::link_state_t next_s;

	// SDA is stable around every rising SCL edge, so it is sampled here unsynchronised
	always_comb begin
		next_s = s;
		if (s.cnt == dvs_pkg::BITS_PER_BYTE) begin
			next_s.cnt = '0;
		end else begin
			next_s.shift = {s.shift[6:0], sda_in};
			next_s.cnt = s.cnt + 4'h1;
			if (s.cnt == dvs_pkg::BITS_PER_BYTE - 4'h1) begin
				next_s.rx.data = {s.shift[6:0], sda_in};
				next_s.rx.tog = ~s.rx.tog;
			end
		end
	end

	// Cleared at every start, while SCL is still high, so counting restarts per frame
	always_ff @(posedge scl_clk or negedge clear_n) begin
		if (!clear_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign rx = s.rx;
endmodule

// ---- src/dvs_i2c_register_control.sv ----
`timescale 1ns/10ps
// Contract
// - A stop condition returns the bus interface from high-speed to normal speed.
// - Reads from addresses outside the four registers return FFh.
// - Every byte received after a matching slave address is acknowledged by SDA low over the next clock high.
// - Write data commits at the SCL fall ending the data byte's last bit.
// - Enable pin low blocks bus updates; enable bit low does not.
// - Answer only slave addresses 10010 plus the two option bits.
// - Register byte upper six bits zero; low two select floor, roof, mode, ramp.
// - Hardware strategy: select pin picks floor or roof; writing selected ramps now.
// - Hardware strategy: writing the unselected register leaves the output unchanged.
// - Software strategy ramps to roof after go bit, clearing it on arrival.
// - Single-step pulse-frequency mode lowering holds power good low until pulsing resumes.
// - Power good low through multi-step ramps, else when output below target.
// - Rate field 111 is single-step default; rising moves at maximum slew.
// - Single-step falling: immediate for forced PWM, uncontrolled for PFM targets.
// - Rate fields 000 to 110 space micro-steps in every strategy and mode.
// - Each voltage register holds a six-bit step code from 0 to 63.
// - Bit 6 of both voltage registers is one shared inductor option bit.
// - Bit 7 of both voltage registers is the shared converter enable bit.
// - Both voltage registers reset with bits 7 and 6 set, code bits by option.
// - Enable pin rising resets all registers; enable bit alone changes nothing.
// - High-speed master code is not acknowledged but switches to high speed.
// - Operating mode follows floor mode bit or roof mode bit per select pin.
module dvs_i2c_register_control #(
	parameter int         STEP_CYCLES      = dvs_pkg::STEP_CYCLES,
	parameter logic [1:0] ADDR_OPTION      = dvs_pkg::ADDR_OPTION_DEF,
	parameter logic [5:0] FLOOR_CODE_RESET = dvs_pkg::FLOOR_CODE_DEF,
	parameter logic [5:0] ROOF_CODE_RESET  = dvs_pkg::ROOF_CODE_DEF
) (
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       scl_clk,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       enable_pin,
	input  wire logic       voltage_select_pin,
	input  wire logic       vout_below_target,
	input  wire logic       converter_pulsing,
	output logic [5:0]      vout_code,
	output logic            converter_on,
	output logic            forced_pwm,
	output logic            light_pfm_inductor_opt,
	output logic            power_good_output,
	output logic            hs_mode
);
	dvs_pkg::core_state_t s;
	dvs_pkg::core_state_t next_s;
	dvs_pkg::pins_t       pin_now;
	dvs_pkg::link_byte_t  rx;
	logic                 link_clear_n;
	logic                 strat;
	logic                 single;
	logic                 tgt_pwm;
	logic [5:0]           target;
	logic [15:0]          spacing;
	logic [7:0]           rd_val;
	logic                 scl_rise;
	logic                 scl_fall;
	logic                 start_c;
	logic                 stop_c;

	assign pin_now = '{scl: scl_in, sda: sda_in, en: enable_pin, sel: voltage_select_pin,
	                   below: vout_below_target, pulse: converter_pulsing};

	// Link clear is a flop, so the receiver's async reset cannot glitch
	assign link_clear_n = rstn & ~s.lclr;

	link_byte_receiver u_rx (
		.scl_clk (scl_clk),
		.clear_n (link_clear_n),
		.sda_in  (sda_in),
		.rx      (rx)
	);

	assign scl_rise = s.s2.scl & ~s.pv.scl;
	assign scl_fall = ~s.s2.scl & s.pv.scl;
	assign start_c  = s.s2.scl & s.pv.scl & ~s.s2.sda & s.pv.sda;
	assign stop_c   = s.s2.scl & s.pv.scl & s.s2.sda & ~s.pv.sda;

	assign strat   = s.ramp_c[dvs_pkg::BIT_STRATEGY];
	assign single  = s.ramp_c[dvs_pkg::RATE_MSB:0] == dvs_pkg::RATE_SINGLE;
	assign tgt_pwm = s.s2.sel ? s.mode_c[dvs_pkg::BIT_ROOF_MODE]
	                          : s.mode_c[dvs_pkg::BIT_FLOOR_MODE];
	assign spacing = 16'(STEP_CYCLES << s.ramp_c[dvs_pkg::RATE_MSB:0]);

	// Target code: pin-selected register, or roof only once software sets go
	always_comb begin
		if (strat) begin
			target = s.s2.sel ? s.roof_v[dvs_pkg::CODE_MSB:0]
			                  : s.floor_v[dvs_pkg::CODE_MSB:0];
		end else if (s.ramp_c[dvs_pkg::BIT_GO]) begin
			target = s.roof_v[dvs_pkg::CODE_MSB:0];
		end else begin
			target = s.vout;
		end
	end

	always_comb begin
		if (s.ptr_bad) begin
			rd_val = dvs_pkg::READ_MISS;
		end else begin
			case (s.ptr)
				dvs_pkg::REG_FLOOR: rd_val = s.floor_v;
				dvs_pkg::REG_ROOF:  rd_val = s.roof_v;
				dvs_pkg::REG_MODE:  rd_val = s.mode_c;
				default:            rd_val = s.ramp_c;
			endcase
		end
	end

	always_comb begin
		logic       ack;
		logic       drive;
		logic [7:0] b;
		ack = 1'b0;
		drive = 1'b0;
		b = s.byte_q;
		next_s = s;
		next_s.s1 = pin_now;
		next_s.s2 = s.s1;
		next_s.pv = s.s2;
		next_s.t1 = rx.tog;
		next_s.t2 = s.t1;
		next_s.t3 = s.t2;

		// Ramp engine runs first so a bus write in the same cycle wins over its clears
		if (!strat && s.ramp_c[dvs_pkg::BIT_GO] && s.vout == s.roof_v[dvs_pkg::CODE_MSB:0]) begin
			next_s.ramp_c[dvs_pkg::BIT_GO] = 1'b0;
		end
		next_s.step_cnt = '0;
		if (single) begin
			if (target != s.vout) begin
				next_s.vout = target;
			end
			if (target < s.vout && !tgt_pwm) begin
				next_s.pfm_hold = 1'b1;
			end
		end else if (target != s.vout) begin
			if (s.step_cnt >= spacing - 16'h1) begin
				next_s.vout = (target > s.vout) ? s.vout + 6'h1 : s.vout - 6'h1;
			end else begin
				next_s.step_cnt = s.step_cnt + 16'h1;
			end
		end
		// Hold ends on the first pulse seen after it began
		if (s.pfm_hold && s.s2.pulse && !s.pv.pulse && !next_s.pfm_hold) begin
			next_s.pfm_hold = 1'b0;
		end else if (s.pfm_hold && s.s2.pulse && !s.pv.pulse && !(target < s.vout)) begin
			next_s.pfm_hold = 1'b0;
		end
		next_s.conv_on = s.s2.en & s.floor_v[dvs_pkg::BIT_ENABLE];
		next_s.fpwm = tgt_pwm;
		next_s.pgood = s.conv_on && !(!single && target != s.vout) && !s.pfm_hold
		               && !s.s2.below;

		// Byte handed over from the link domain
		if ((s.t2 ^ s.t3) && !s.lclr && s.st != dvs_pkg::ST_READ
		    && s.st != dvs_pkg::ST_IDLE) begin
			next_s.pend = 1'b1;
			next_s.byte_q = rx.data;
		end

		if (scl_fall) begin
			if (s.ack_ph) begin
				next_s.ack_ph = 1'b0;
				next_s.sda_oe = 1'b0;
				if (s.st == dvs_pkg::ST_READ) begin
					next_s.sh = rd_val;
					next_s.rd_cnt = '0;
					drive = 1'b1;
				end
			end else if (s.st == dvs_pkg::ST_READ && !s.rd_wait) begin
				drive = 1'b1;
			end
			if (drive) begin
				if (next_s.rd_cnt < dvs_pkg::BITS_PER_BYTE) begin
					next_s.sda_oe = ~next_s.sh[7];
					next_s.sh = {next_s.sh[6:0], 1'b0};
					next_s.rd_cnt = next_s.rd_cnt + 4'h1;
				end else begin
					next_s.sda_oe = 1'b0;
					next_s.rd_wait = 1'b1;
					next_s.rd_cnt = '0;
				end
			end
			if (s.pend) begin
				next_s.pend = 1'b0;
				case (s.st)
					dvs_pkg::ST_ADDR: begin
						if (b[7:3] == dvs_pkg::HS_CODE_TOP) begin
							next_s.hs = 1'b1;
							next_s.st = dvs_pkg::ST_SKIP;
						end else if (b[7:1] == {dvs_pkg::ADDR_FIXED, ADDR_OPTION}) begin
							ack = 1'b1;
							next_s.st = b[0] ? dvs_pkg::ST_READ : dvs_pkg::ST_REG;
							next_s.rd_wait = 1'b0;
						end else begin
							next_s.st = dvs_pkg::ST_SKIP;
						end
					end
					dvs_pkg::ST_REG: begin
						ack = 1'b1;
						next_s.ptr = b[1:0];
						next_s.ptr_bad = |b[7:2];
						next_s.st = dvs_pkg::ST_DATA;
					end
					dvs_pkg::ST_DATA: begin
						ack = 1'b1;
						if (!s.ptr_bad) begin
							case (s.ptr)
								dvs_pkg::REG_FLOOR: begin
									next_s.floor_v = b;
									next_s.roof_v[7:6] = b[7:6];
								end
								dvs_pkg::REG_ROOF: begin
									next_s.roof_v = b;
									next_s.floor_v[7:6] = b[7:6];
								end
								dvs_pkg::REG_MODE: next_s.mode_c = b;
								default:           next_s.ramp_c = b;
							endcase
						end
					end
					default: begin
					end
				endcase
				if (ack) begin
					next_s.sda_oe = 1'b1;
					next_s.ack_ph = 1'b1;
				end
			end
		end

		// Master acknowledge after each read byte; a high level ends the read
		if (scl_rise && s.st == dvs_pkg::ST_READ && s.rd_wait && !s.ack_ph) begin
			if (s.s2.sda) begin
				next_s.st = dvs_pkg::ST_SKIP;
			end else begin
				next_s.rd_wait = 1'b0;
				next_s.sh = rd_val;
			end
		end

		if (!s.s2.scl) begin
			next_s.lclr = 1'b0;
		end
		if (start_c || stop_c) begin
			next_s.st = start_c ? dvs_pkg::ST_ADDR : dvs_pkg::ST_IDLE;
			next_s.lclr = start_c;
			next_s.pend = 1'b0;
			next_s.ack_ph = 1'b0;
			next_s.sda_oe = 1'b0;
			next_s.rd_wait = 1'b0;
		end
		if (stop_c) begin
			next_s.hs = 1'b0;
		end
		// Hardware shutdown: bus ignored entirely, link held cleared
		if (!s.s2.en) begin
			next_s.st = dvs_pkg::ST_IDLE;
			next_s.lclr = 1'b1;
			next_s.pend = 1'b0;
			next_s.ack_ph = 1'b0;
			next_s.sda_oe = 1'b0;
			next_s.hs = 1'b0;
		end
		if (s.s2.en && !s.pv.en) begin
			next_s.floor_v = {dvs_pkg::VOLT_TOP_RESET, FLOOR_CODE_RESET};
			next_s.roof_v = {dvs_pkg::VOLT_TOP_RESET, ROOF_CODE_RESET};
			next_s.mode_c = dvs_pkg::MODE_RESET;
			next_s.ramp_c = dvs_pkg::RAMP_RESET;
		end
		next_s.sda_lvl = 1'b0;
	end

	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			s <= '0;
			s.lclr <= 1'b1;
			s.floor_v <= {dvs_pkg::VOLT_TOP_RESET, FLOOR_CODE_RESET};
			s.roof_v <= {dvs_pkg::VOLT_TOP_RESET, ROOF_CODE_RESET};
			s.mode_c <= dvs_pkg::MODE_RESET;
			s.ramp_c <= dvs_pkg::RAMP_RESET;
		end else begin
			s <= next_s;
		end
	end

	assign sda_out = s.sda_lvl;
	assign sda_oe = s.sda_oe;
	assign vout_code = s.vout;
	assign converter_on = s.conv_on;
	assign forced_pwm = s.fpwm;
	assign light_pfm_inductor_opt = s.floor_v[dvs_pkg::BIT_LPFM];
	assign power_good_output = s.pgood;
	assign hs_mode = s.hs;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	property p_stop_hs;
		stop_c |=> !s.hs;
	endproperty
	a_stop_hs: assert property (p_stop_hs) else $error("high speed kept after stop");

	property p_miss_ff;
		s.st == dvs_pkg::ST_READ && s.ptr_bad && !s.ack_ph |-> !s.sda_oe;
	endproperty
	a_miss_ff: assert property (p_miss_ff) else $error("unmapped read drove a zero");

	property p_ack_hold;
		$rose(s.ack_ph) |-> s.sda_oe [*2];
	endproperty
	a_ack_hold: assert property (p_ack_hold) else $error("acknowledge not held");

	property p_commit;
		scl_fall && s.pend && s.st == dvs_pkg::ST_DATA && !s.ptr_bad
		&& s.ptr == dvs_pkg::REG_MODE && s.s2.en && !stop_c |=> s.mode_c == $past(s.byte_q);
	endproperty
	a_commit: assert property (p_commit) else $error("write not committed");

	property p_en_low;
		!s.s2.en |=> !s.sda_oe && s.st == dvs_pkg::ST_IDLE;
	endproperty
	a_en_low: assert property (p_en_low) else $error("bus active in shutdown");

	property p_addr_miss;
		scl_fall && s.pend && s.st == dvs_pkg::ST_ADDR
		&& s.byte_q[7:3] != dvs_pkg::ADDR_FIXED |=> !s.sda_oe;
	endproperty
	a_addr_miss: assert property (p_addr_miss) else $error("foreign address acked");

	property p_mirror;
		s.floor_v[7:6] == s.roof_v[7:6];
	endproperty
	a_mirror: assert property (p_mirror) else $error("shared bits differ");

	property p_en_reset;
		s.s2.en && !s.pv.en |=> s.ramp_c == dvs_pkg::RAMP_RESET && s.floor_v[6];
	endproperty
	a_en_reset: assert property (p_en_reset) else $error("registers not reset");

	property p_single_up;
		single && target > s.vout |=> s.vout == $past(target);
	endproperty
	a_single_up: assert property (p_single_up) else $error("single step rise slow");

	property p_multi_pg;
		!single && target != s.vout |=> !s.pgood;
	endproperty
	a_multi_pg: assert property (p_multi_pg) else $error("power good during ramp");

	property p_sw_hold;
		!strat && !s.ramp_c[dvs_pkg::BIT_GO] |=> $stable(s.vout);
	endproperty
	a_sw_hold: assert property (p_sw_hold) else $error("software mode moved early");

	c_write: cover property (s.st == dvs_pkg::ST_DATA && scl_fall && s.pend);
	c_read: cover property (s.st == dvs_pkg::ST_READ && s.rd_wait);
	c_hs: cover property (s.hs ##1 stop_c);
	c_ramp: cover property (!single && target != s.vout ##1 target == s.vout);
endmodule

// ---- testbench/i2c_host_model.sv ----
`timescale 1ns/10ps
module i2c_host_model (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Quarter of an SCL period; the full period is stretched so the core sees every edge
	localparam int Q = 32;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// Also serves as repeated start; SCL parks high between frames
	task automatic start();
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#(2*Q) sda_low = 1'b1;
		#(6*Q) scl = 1'b0;
	endtask

	// Ending with stop, not repeated start, drops high-speed operation
	task automatic stop();
		#Q sda_low = 1'b1;
		#Q scl = 1'b1;
		#(2*Q) sda_low = 1'b0;
		#(4*Q);
	endtask

	// Data moves a quarter after SCL falls, away from the start/stop window
	task automatic send(input logic [7:0] b, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			#Q sda_low = !b[i];
			#Q scl = 1'b1;
			#(2*Q) scl = 1'b0;
		end
		#Q sda_low = 1'b0;
		#Q scl = 1'b1;
		#Q ack = !sda;
		#Q scl = 1'b0;
	endtask

	task automatic recv(input logic more, output logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			#Q sda_low = 1'b0;
			#Q scl = 1'b1;
			#Q b[i] = sda;
			#Q scl = 1'b0;
		end
		#Q sda_low = more;
		#Q scl = 1'b1;
		#(2*Q) scl = 1'b0;
	endtask
endmodule

// ---- testbench/dvs_i2c_register_control_tb_top.sv ----
`timescale 1ns/10ps
module dvs_i2c_register_control_tb_top;
	localparam int STEPS = 2;
	logic       core_clk = 1'b0;
	logic       rstn = 1'b0;
	logic       scl;
	logic       host_low;
	logic       sda_out;
	logic       sda_oe;
	logic       sda;
	logic       enable_pin = 1'b0;
	logic       sel_pin = 1'b0;
	logic       below = 1'b0;
	logic       pulsing = 1'b0;
	logic [5:0] vout_code;
	logic       converter_on;
	logic       forced_pwm;
	logic       lpfm;
	logic       pgood;
	logic       hs_mode;
	logic       ack_bit;
	logic [7:0] exp_reg [4];
	logic [7:0] rnd_reg;
	logic [7:0] rnd_dat;
	integer     seed = 54996;
	int         mismatches = 0;
	int         checks = 0;
	int         cyc = 0;

	// Open-drain wire with pull-up
	assign sda = !(host_low || (sda_oe && !sda_out));

	always #5 core_clk = ~core_clk;

	dvs_i2c_register_control #(.STEP_CYCLES(STEPS)) dut_u (
		.core_clk(core_clk), .rstn(rstn), .scl_clk(scl), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .enable_pin(enable_pin),
		.voltage_select_pin(sel_pin), .vout_below_target(below),
		.converter_pulsing(pulsing), .vout_code(vout_code), .converter_on(converter_on),
		.forced_pwm(forced_pwm), .light_pfm_inductor_opt(lpfm),
		.power_good_output(pgood), .hs_mode(hs_mode)
	);

	i2c_host_model host_u (.scl(scl), .sda_low(host_low), .sda(sda));

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Whole run needs about 25k cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 80000) begin
			mismatches++;
			$display("BAD %0t timeout", $time);
			wrap_up();
		end
	end

	task automatic ck8(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t byte %h expected %h", $time, got, exp);
		end
	endtask

	task automatic ck1(input logic got, input logic exp);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t flag %b expected %b", $time, got, exp);
		end
	endtask

	task automatic pins(input logic en, input logic vs, input logic bl, input logic pl);
		@(posedge core_clk) #1;
		enable_pin = en;
		sel_pin = vs;
		below = bl;
		pulsing = pl;
	endtask

	task automatic wait_vout(input logic [5:0] v, input int lim);
		int n;
		n = 0;
		while (vout_code !== v && n < lim) begin
			@(posedge core_clk);
			n++;
		end
		#1;
		ck8({2'h0, vout_code}, {2'h0, v});
	endtask

	// Slave address 10010 with option 00; model updated only for register bytes with zero upper bits
	task automatic wr(input logic [7:0] ra, input logic [7:0] d, input logic exp_ack);
		logic ack_adr;
		logic ack_reg;
		logic ack_dat;
		host_u.start();
		host_u.send(8'h90, ack_adr);
		host_u.send(ra, ack_reg);
		host_u.send(d, ack_dat);
		host_u.stop();
		ck1(ack_adr & ack_reg & ack_dat, exp_ack);
		if (exp_ack && ra < 8'h04) begin
			exp_reg[ra[1:0]] = d;
			if (ra < 8'h02) exp_reg[ra[1:0] ^ 2'h1][7:6] = d[7:6];
		end
	endtask

	task automatic rd(input logic [7:0] ra);
		logic       ack_adr;
		logic       ack_reg;
		logic       ack_rda;
		logic [7:0] b;
		host_u.start();
		host_u.send(8'h90, ack_adr);
		host_u.send(ra, ack_reg);
		host_u.start();
		host_u.send(8'h91, ack_rda);
		host_u.recv(1'b0, b);
		host_u.stop();
		ck1(ack_adr & ack_reg & ack_rda, 1'b1);
		ck8(b, (ra < 8'h04) ? exp_reg[ra[1:0]] : 8'hFF);
	endtask

	initial begin
		repeat (5) @(posedge core_clk);
		#1 rstn = 1'b1;
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge core_clk);
		exp_reg = '{8'hC0, 8'hC0, 8'h00, 8'h07};
		for (int r = 0; r < 5; r++) rd(r[7:0]);
		ck1(converter_on, 1'b1);
		ck1(lpfm, 1'b1);
		foreach (exp_reg[i]) begin
			host_u.start();
			host_u.send(8'h92 + 8'h02 * i[7:0] + 8'h40 * (i == 3), ack_bit);
			host_u.stop();
			ck1(ack_bit, 1'b0);
		end
		wr(8'h41, 8'h55, 1'b1);
		rd(8'h41);
		rd(8'h01);
		// Go bit kept clear so hardware never edits the ramp register under the model
		for (int k = 0; k < 12; k++) begin
			rnd_reg = 8'($random(seed)) & 8'h03;
			rnd_dat = 8'($random(seed));
			if (rnd_reg == 8'h03) rnd_dat = rnd_dat & 8'hDF;
			wr(rnd_reg, rnd_dat, 1'b1);
			rd(rnd_reg);
			ck1(converter_on, exp_reg[0][7]);
			ck1(lpfm, exp_reg[0][6]);
			ck1(forced_pwm, exp_reg[2][0]);
		end
		wr(8'h03, 8'h17, 1'b1);
		wr(8'h02, 8'h03, 1'b1);
		pins(1'b1, 1'b0, 1'b0, 1'b1);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		wr(8'h00, 8'h95, 1'b1);
		wait_vout(6'h15, 0);
		wr(8'h01, 8'hAA, 1'b1);
		wait_vout(6'h15, 0);
		pins(1'b1, 1'b1, 1'b0, 1'b0);
		wait_vout(6'h2A, 8);
		ck1(forced_pwm, 1'b1);
		wr(8'h03, 8'h07, 1'b1);
		wr(8'h01, 8'hB0, 1'b1);
		wait_vout(6'h2A, 0);
		wr(8'h03, 8'h27, 1'b1);
		wait_vout(6'h30, 10);
		exp_reg[3] = 8'h07;
		rd(8'h03);
		wr(8'h03, 8'h16, 1'b1);
		wr(8'h01, 8'hB4, 1'b1);
		ck1(pgood, 1'b0);
		ck1(vout_code == 6'h34, 1'b0);
		wait_vout(6'h34, 2000);
		repeat (4) @(posedge core_clk);
		ck1(pgood, 1'b1);
		pins(1'b1, 1'b1, 1'b1, 1'b0);
		repeat (8) @(posedge core_clk);
		ck1(pgood, 1'b0);
		wr(8'h03, 8'h17, 1'b1);
		wr(8'h02, 8'h00, 1'b1);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		wait_vout(6'h15, 10);
		repeat (10) @(posedge core_clk);
		ck1(pgood, 1'b0);
		pins(1'b1, 1'b0, 1'b0, 1'b1);
		repeat (8) @(posedge core_clk);
		ck1(pgood, 1'b1);
		host_u.start();
		host_u.send(8'h08, ack_bit);
		ck1(ack_bit, 1'b0);
		ck1(hs_mode, 1'b1);
		wr(8'h00, 8'h95, 1'b1);
		ck1(hs_mode, 1'b0);
		pins(1'b0, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge core_clk);
		ck1(converter_on, 1'b0);
		wr(8'h00, 8'hAB, 1'b0);
		// A write taken in shutdown would move the floor target at once
		wait_vout(6'h15, 0);
		pins(1'b1, 1'b0, 1'b0, 1'b0);
		repeat (8) @(posedge core_clk);
		exp_reg = '{8'hC0, 8'hC0, 8'h00, 8'h07};
		for (int r = 0; r < 4; r++) rd(r[7:0]);
		wrap_up();
	end
endmodule
